/* File: shared/adc_port_defines.svh */
// Purpose: constants for the parallel converter host port
// Assumes: one 25 MHz clock, synchronous pins
// Notes: control register layouts beyond the reference select are local choices
// Notes on behaviour
// - first select is active low
// - second select is active high
// - twelve-line tristate bus, bit 0 is lsb
// - line 10 carries low register address
// - line 11 carries high register address
// - sync output marks channel A word
// - hardware reset restores control defaults
// - write strobe is direction line or write strobe
// - read strobe honoured only in split strobe mode
// - host first access must be a write
// - control register 0 selects reference source
// - host supplies the conversion clock
// - conversion clock between 0.1 and 8 MHz
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH
`define BUS_W 12
`define DATA_W 10
`define ADDR_LO_BIT 10
`define ADDR_HI_BIT 11
`define CREG0_RESET 10'h000
`define CREG1_RESET 10'h000
`define REF_EXT_BIT 0
`define STROBE_MODE_BIT 1
`define SCAN_BIT 2
`define CLK_FREQ_KHZ 25000
`define CONV_MIN_KHZ 100
`define CONV_MAX_KHZ 8000
`define CONV_HALF_MAX (`CLK_FREQ_KHZ / (2 * `CONV_MIN_KHZ))
`define CONV_HALF_MIN ((`CLK_FREQ_KHZ + 2 * `CONV_MAX_KHZ - 1) / (2 * `CONV_MAX_KHZ))
`define CONV_HALF_CYC 8'h02
`define SAMPLE_INIT 12'h000
`endif

/* File: shared/adc_port_if.sv */
// Purpose: pins between converter port and host
// Assumes: bus wire resolved by the testbench from the enables
// Notes: output enables are low while driving
`timescale 1ns/100ps
interface adc_port_if;
  import adc_port_pkg::*;
  logic select_low;
  logic select_high;
  logic wr_strobe;
  logic rd_strobe_n;
  logic conversion_clock;
  logic sync;
  bus_word_t bus_dev_out;
  logic bus_dev_oe_n;
  bus_word_t bus_host_out;
  logic bus_host_oe_n;
  bus_word_t bus_in;
  modport device (input select_low, select_high, wr_strobe, rd_strobe_n, conversion_clock, bus_in,
                  output sync, bus_dev_out, bus_dev_oe_n);
  modport host (output select_low, select_high, wr_strobe, rd_strobe_n, conversion_clock,
                bus_host_out, bus_host_oe_n, input sync, bus_in);
endinterface : adc_port_if

/* File: shared/adc_port_pkg.sv */
// Purpose: types for the parallel converter host port
// Assumes: constants come from adc_port_defines.svh
// Notes: none
`include "adc_port_defines.svh"
package adc_port_pkg;
  typedef logic [`BUS_W-1:0] bus_word_t;
  typedef logic [`DATA_W-1:0] ctrl_word_t;
  typedef enum logic {STROBE_RW, STROBE_SPLIT} strobe_mode_t;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_DONE} host_state_t;
endpackage : adc_port_pkg

/* File: verification/adc_parallel_host_port_tb.sv */
// Purpose: host and device ends joined and exercised
// Assumes: 25 MHz clock, synchronous reset
// Notes: scan is taken to start on channel A
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_parallel_host_port_tb;
  import adc_port_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [1:0] req_addr_i = 2'h0;
  ctrl_word_t req_data_i = 10'h000;
  logic split_mode_i = 1'b0;
  bus_word_t sample_a_i = 12'ha5c;
  bus_word_t sample_b_i = 12'h3e1;
  logic ref_external_o, strobe_split_o, scan_o, busy_o, done_o, rsync_o, conv_tick_o;
  bus_word_t rdata_o;
  int err_count = 0;
  int checked = 0;
  adc_port_if link();
  assign link.bus_in = !link.bus_dev_oe_n ? link.bus_dev_out : !link.bus_host_oe_n ? link.bus_host_out : 'z;
  always #20 ref_clk_i = !ref_clk_i;
  adc_port_device adc_port_device_inst (.ref_clk_i, .rst_n_i, .link(link), .sample_a_i, .sample_b_i,
    .ref_external_o, .strobe_split_o, .scan_o, .conv_tick_o);
  adc_port_host adc_port_host_inst (.ref_clk_i, .rst_n_i, .link(link), .req_i, .req_write_i, .req_addr_i,
    .req_data_i, .split_mode_i, .busy_o, .done_o, .rdata_o, .rsync_o);
  adc_port_properties adc_port_properties_inst (.ref_clk_i, .rst_n_i, .select_low(link.select_low),
    .select_high(link.select_high), .wr_strobe(link.wr_strobe), .rd_strobe_n(link.rd_strobe_n),
    .conversion_clock(link.conversion_clock), .bus_dev_oe_n(link.bus_dev_oe_n),
    .bus_host_oe_n(link.bus_host_oe_n), .strobe_split_o);
  // ****************
  // tasks
  // ****************
  task chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task access(input logic w, input logic [1:0] a, input ctrl_word_t d, input logic s);
    int n;
    @(posedge ref_clk_i);
    #1;
    {req_i, req_write_i, req_addr_i, req_data_i, split_mode_i} = {1'b1, w, a, d, s};
    for (n = 0; n < 20 && done_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (busy_o === 1'b1) req_i = 1'b0;
      if (w && !link.select_low && !link.wr_strobe) chk(link.bus_in, {a, d});
    end
    chk(done_o, 13'h0001);
  endtask : access
  task t_write_split;
    access(1'b1, 2'h0, 10'h007, 1'b1);
    chk({ref_external_o, strobe_split_o, scan_o}, 13'h0007);
  endtask : t_write_split
  task t_scan_read;
    access(1'b0, 2'h0, 10'h000, 1'b1);
    chk({rsync_o, rdata_o}, {1'b1, sample_a_i});
    access(1'b0, 2'h0, 10'h000, 1'b1);
    chk({rsync_o, rdata_o}, {1'b0, sample_b_i});
  endtask : t_scan_read
  task t_rw_mode;
    access(1'b1, 2'h2, 10'h3ff, 1'b1);
    access(1'b1, 2'h1, 10'h3ff, 1'b1);
    chk({ref_external_o, strobe_split_o, scan_o}, 13'h0007);
    access(1'b1, 2'h0, 10'h000, 1'b0);
    chk({ref_external_o, strobe_split_o, scan_o}, 13'h0000);
    access(1'b0, 2'h0, 10'h000, 1'b0);
    chk({rsync_o, rdata_o}, {1'b1, sample_a_i});
  endtask : t_rw_mode
  task t_reset;
    access(1'b1, 2'h0, 10'h007, 1'b1);
    rst_n_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({ref_external_o, strobe_split_o, scan_o, link.bus_dev_oe_n}, 13'h0001);
    rst_n_i = 1'b1;
    req_write_i = 1'b0;
    req_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({busy_o, link.select_low}, 13'h0001);
    req_i = 1'b0;
    access(1'b1, 2'h0, 10'h001, 1'b0);
    chk({ref_external_o, strobe_split_o}, 13'h0002);
  endtask : t_reset
  task t_conv_tick;
    int n;
    @(posedge link.conversion_clock);
    @(posedge ref_clk_i);
    #1;
    chk(conv_tick_o, 13'h0001);
    for (n = 1; n < 300; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (conv_tick_o === 1'b1) break;
    end
    chk(n, 2 * (`CONV_HALF_CYC + 1));
  endtask : t_conv_tick
  task end_of_test;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // ****************
  // sequence and watchdog
  // ****************
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_write_split();
    t_scan_read();
    t_rw_mode();
    t_reset();
    t_conv_tick();
    end_of_test();
  end
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule : adc_parallel_host_port_tb

/* File: verification/adc_port_properties.sv */
// Purpose: pin-level properties of the converter port link
// Assumes: one clock, synchronous active-low reset
// Notes: split mode taken from the device's mode output
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_port_properties (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link pins
  input wire logic select_low,
  input wire logic select_high,
  input wire logic wr_strobe,
  input wire logic rd_strobe_n,
  input wire logic conversion_clock,
  input wire logic bus_dev_oe_n,
  input wire logic bus_host_oe_n,
  // device mode
  input wire logic strobe_split_o
);
  localparam int HALF_MIN = `CONV_HALF_MIN;
  localparam int HALF_MAX = `CONV_HALF_MAX;
  logic clk_q;
  logic [7:0] cnt_q;
  wire logic sel = !select_low && select_high;
  wire logic rd = sel && (strobe_split_o ? !rd_strobe_n : wr_strobe);
  // half-period counter of the conversion clock
  always_ff @(posedge ref_clk_i) begin
    clk_q <= conversion_clock;
    cnt_q <= (!rst_n_i || conversion_clock != clk_q) ? 8'h00 : cnt_q + 8'h01;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_start;
    !rd ##1 rd;
  endsequence
  sequence rd_end;
    rd ##1 !rd;
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) !rst_n_i |=> bus_dev_oe_n && bus_host_oe_n && select_low)
    else $error("link not idle after reset");
  select_pair_a: assert property (select_low == !select_high)
    else $error("selects disagree");
  read_drive_a: assert property (rd_start ##1 rd |-> !bus_dev_oe_n)
    else $error("read not answered");
  read_release_a: assert property (rd_end |=> bus_dev_oe_n)
    else $error("bus held after read");
  idle_release_a: assert property (!rd |=> bus_dev_oe_n)
    else $error("bus driven outside read");
  one_driver_a: assert property (bus_dev_oe_n || bus_host_oe_n)
    else $error("bus contention");
  write_data_a: assert property (sel && !wr_strobe |-> !bus_host_oe_n)
    else $error("write strobe without data");
  conv_min_a: assert property (conversion_clock != clk_q |-> cnt_q >= HALF_MIN - 1)
    else $error("conversion clock too fast");
  conv_max_a: assert property (cnt_q < HALF_MAX)
    else $error("conversion clock too slow");
endmodule : adc_port_properties

/* File: verilog/adc_port_device.sv */
// Purpose: device end of the parallel converter port
// Assumes: pins synchronous to ref_clk_i
// Notes: samples come in from the converter core on a user port
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_port_device (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link
  adc_port_if.device link,
  // converter core side
  input wire adc_port_pkg::bus_word_t sample_a_i,
  input wire adc_port_pkg::bus_word_t sample_b_i,
  output logic ref_external_o,
  output logic strobe_split_o,
  output logic scan_o,
  output logic conv_tick_o
);
  import adc_port_pkg::*;

  // ********
  // state
  // ********
  ctrl_word_t creg0_q, creg0_d;
  ctrl_word_t creg1_q, creg1_d;
  bus_word_t out_q, out_d;
  logic oe_n_q, oe_n_d;
  logic sync_q, sync_d;
  logic chan_b_q, chan_b_d;
  logic wr_prev_q, wr_prev_d;
  logic rd_prev_q, rd_prev_d;
  logic cclk_prev_q, cclk_prev_d;
  logic tick_q, tick_d;
  logic sel, wr_edge, rd_edge, rd_active, is_write;
  strobe_mode_t mode;

  // ********
  // access decode
  // ********
  always_comb begin
    sel = !link.select_low && link.select_high;
    mode = strobe_mode_t'(creg0_q[`STROBE_MODE_BIT]);
    // split mode: write on rising edge of write strobe; rw mode: write strobe high means read
    if (mode == STROBE_SPLIT) begin
      wr_edge = sel && link.wr_strobe && wr_prev_q;
      rd_active = sel && !link.rd_strobe_n;
      is_write = sel && !link.wr_strobe;
    end else begin
      wr_edge = sel && !link.wr_strobe && !wr_prev_q;
      rd_active = sel && link.wr_strobe;
      is_write = sel && !link.wr_strobe;
    end
    rd_edge = rd_active && !rd_prev_q;
  end

  // ********
  // registers and read path
  // ********
  always_comb begin
    creg0_d = creg0_q;
    creg1_d = creg1_q;
    out_d = out_q;
    chan_b_d = chan_b_q;
    sync_d = sync_q;
    oe_n_d = !(rd_active && !is_write);
    wr_prev_d = sel && !link.wr_strobe;
    rd_prev_d = rd_active;
    cclk_prev_d = link.conversion_clock;
    tick_d = link.conversion_clock && !cclk_prev_q;
    if (wr_edge) begin
      // high address on line 11, low on line 10
      unique case ({link.bus_in[`ADDR_HI_BIT], link.bus_in[`ADDR_LO_BIT]})
        2'b00: creg0_d = link.bus_in[`DATA_W-1:0];
        2'b01: creg1_d = link.bus_in[`DATA_W-1:0];
        default: ;
      endcase
    end
    if (rd_edge) begin
      out_d = chan_b_q ? sample_b_i : sample_a_i;
      sync_d = !chan_b_q;
      chan_b_d = creg0_q[`SCAN_BIT] ? !chan_b_q : 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      creg0_q <= `CREG0_RESET;
      creg1_q <= `CREG1_RESET;
      out_q <= `SAMPLE_INIT;
      oe_n_q <= 1'b1;
      sync_q <= 1'b0;
      chan_b_q <= 1'b0;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      cclk_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      creg0_q <= creg0_d;
      creg1_q <= creg1_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      sync_q <= sync_d;
      chan_b_q <= chan_b_d;
      wr_prev_q <= wr_prev_d;
      rd_prev_q <= rd_prev_d;
      cclk_prev_q <= cclk_prev_d;
      tick_q <= tick_d;
    end
  end

  // ********
  // outputs
  // ********
  assign link.bus_dev_out = out_q;
  assign link.bus_dev_oe_n = oe_n_q;
  assign link.sync = sync_q;
  assign ref_external_o = creg0_q[`REF_EXT_BIT];
  assign strobe_split_o = creg0_q[`STROBE_MODE_BIT];
  assign scan_o = creg0_q[`SCAN_BIT];
  assign conv_tick_o = tick_q;
endmodule : adc_port_device

/* File: verilog/adc_port_host.sv */
// Purpose: host end of the parallel converter port
// Assumes: pins synchronous to ref_clk_i
// Notes: one access at a time, four cycles each
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_port_host (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link
  adc_port_if.host link,
  // user requests
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_addr_i,
  input wire adc_port_pkg::ctrl_word_t req_data_i,
  input wire logic split_mode_i,
  output logic busy_o,
  output logic done_o,
  output adc_port_pkg::bus_word_t rdata_o,
  output logic rsync_o
);
  import adc_port_pkg::*;

  // ********
  // state
  // ********
  host_state_t st_q, st_d;
  logic wr_q, wr_d;
  logic split_q, split_d;
  logic split_next_q, split_next_d;
  logic inited_q, inited_d;
  bus_word_t wdata_q, wdata_d;
  bus_word_t rdata_q, rdata_d;
  logic rsync_q, rsync_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic cs_q, cs_d;
  logic sel_n_q, sel_n_d;
  logic wrs_q, wrs_d;
  logic rds_q, rds_d;
  logic oe_n_q, oe_n_d;
  logic cclk_q, cclk_d;
  logic [7:0] div_q, div_d;
  logic take_req;

  // ********
  // conversion clock divider
  // ********
  always_comb begin
    div_d = div_q + 8'h01;
    cclk_d = cclk_q;
    if (div_q == `CONV_HALF_CYC) begin
      div_d = 8'h00;
      cclk_d = !cclk_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      div_q <= 8'h00;
      cclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cclk_q <= cclk_d;
    end
  end

  // ********
  // access sequencer
  // ********
  always_comb begin
    // a read before the first write is refused by turning it into nothing
    take_req = req_i && (req_write_i || inited_q);
    st_d = st_q;
    wr_d = wr_q;
    split_d = split_q;
    split_next_d = split_next_q;
    inited_d = inited_q;
    wdata_d = wdata_q;
    unique case (st_q)
      H_IDLE: begin
        if (take_req) begin
          st_d = H_SETUP;
          wr_d = req_write_i;
          split_next_d = req_write_i ? split_mode_i : split_q;
          wdata_d = {req_addr_i[1], req_addr_i[0], req_data_i};
        end
      end
      H_SETUP: begin
        st_d = H_STROBE;
      end
      H_STROBE: begin
        st_d = H_DONE;
      end
      H_DONE: begin
        st_d = H_IDLE;
        // the new strobe shape holds only once the device has latched it
        split_d = split_next_q;
        if (wr_q) begin
          inited_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= H_IDLE;
      wr_q <= 1'b0;
      split_q <= 1'b0;
      split_next_q <= 1'b0;
      inited_q <= 1'b0;
      wdata_q <= 12'h000;
    end else begin
      st_q <= st_d;
      wr_q <= wr_d;
      split_q <= split_d;
      split_next_q <= split_next_d;
      inited_q <= inited_d;
      wdata_q <= wdata_d;
    end
  end

  // ********
  // pin drivers
  // ********
  always_comb begin
    cs_d = cs_q;
    wrs_d = wrs_q;
    rds_d = rds_q;
    oe_n_d = oe_n_q;
    rdata_d = rdata_q;
    rsync_d = rsync_q;
    done_d = 1'b0;
    unique case (st_q)
      H_IDLE: begin
        if (take_req) begin
          cs_d = 1'b1;
          // the access uses the strobe shape the device holds now
          wrs_d = req_write_i ? split_q : 1'b1;
          oe_n_d = !req_write_i;
        end
      end
      H_SETUP: begin
        if (wr_q) begin
          wrs_d = 1'b0;
        end else if (split_q) begin
          rds_d = 1'b0;
        end
      end
      H_STROBE: begin
        // a split-mode write is latched on this rising edge
        wrs_d = split_q ? 1'b1 : wrs_q;
      end
      H_DONE: begin
        if (!wr_q) begin
          rdata_d = link.bus_in;
          rsync_d = link.sync;
        end
        cs_d = 1'b0;
        oe_n_d = 1'b1;
        wrs_d = 1'b1;
        rds_d = 1'b1;
        done_d = 1'b1;
      end
    endcase
    sel_n_d = !cs_d;
    busy_d = (st_d != H_IDLE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b0;
      sel_n_q <= 1'b1;
      wrs_q <= 1'b1;
      rds_q <= 1'b1;
      oe_n_q <= 1'b1;
      rdata_q <= 12'h000;
      rsync_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cs_q <= cs_d;
      sel_n_q <= sel_n_d;
      wrs_q <= wrs_d;
      rds_q <= rds_d;
      oe_n_q <= oe_n_d;
      rdata_q <= rdata_d;
      rsync_q <= rsync_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // ********
  // outputs
  // ********
  assign link.select_low = sel_n_q;
  assign link.select_high = cs_q;
  assign link.wr_strobe = wrs_q;
  assign link.rd_strobe_n = rds_q;
  assign link.conversion_clock = cclk_q;
  assign link.bus_host_out = wdata_q;
  assign link.bus_host_oe_n = oe_n_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign rsync_o = rsync_q;
endmodule : adc_port_host
